/* File: src/fcs_host.sv */
// Host controller that drives a parallel flash through command sequences
`timescale 1ns/1ps
// What this block does
// - User identifier program: AA, 55, A5 prefix, then address and data.
// - Completion of identifier programming is seen by toggle bit polling only.
// - Lock: AA, 55, 85 prefix, then 0000 anywhere; later programming refused.
// - Identifier read mode entered with AA, 55, then 88 at 555.
// - Special modes exit on F0, either full prefix or single write.
// - Word program: AA, 55, A0 prefix, then word address and data.
// - Erase: six writes ending 50 sector, 30 block or 10 chip.
// - Single B0 write suspends erase; single 30 write resumes it.
// - Identification with 90 prefix; query with 98 prefix or 98 at 55.
// - Upper data byte ignored in commands but driven to valid levels.
module fcs_host
  import fcs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // User command port
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire fcs_op_t     cmd_op_i,
  input  wire logic [20:0] cmd_addr_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        protect_boot_i,
  // User answer port
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             rsp_error_o,
  // Flash pins
  output logic [20:0]      flash_addr_o,
  output logic [15:0]      data_pins_o,
  input  wire logic [15:0] data_pins_i,
  output logic             data_pins_oe_n_o,
  output logic             chip_select_n_o,
  output logic             output_gate_n_o,
  output logic             write_strobe_n_o,
  output logic             hard_reset_n_o,
  output logic             boot_protect_n_o
);

  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL_ISSUE, S_POLL_WAIT, S_RST_LOW, S_RST_HIGH, S_DONE
  } fcs_state_t;

  fcs_state_t  st_q, st_d;
  fcs_op_t     op_q, op_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] data_q, data_d, rsp_q, rsp_d;
  logic [2:0]  step_q, step_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        prev_q, prev_d, polled_q, polled_d, err_q, err_d;
  logic        valid_q, valid_d, rst_n_q, rst_n_d, prot_n_q;
  logic [37:0] word;
  logic        needs_poll;

  fcs_cyc_if cyc ();

  // ------------------------------------------------------------------
  // Command sequence table: {last, address, data} for one step
  // ------------------------------------------------------------------
  function automatic logic [37:0] seq_word(input fcs_op_t op, input logic [2:0] step,
                                           input logic [20:0] a, input logic [15:0] d);
    logic [7:0]  code;
    logic [20:0] wa;
    logic [15:0] wd;
    logic        last;
    logic        erase;
    wa    = ADDR_UNLOCK1;
    wd    = {8'h00, CODE_UNLOCK1};
    last  = 1'b0;
    erase = (op == FCS_OP_SECTOR_ERASE) || (op == FCS_OP_BLOCK_ERASE) ||
            (op == FCS_OP_CHIP_ERASE);
    case (op)
      FCS_OP_PROGRAM:     code = CODE_PROGRAM;
      FCS_OP_SEC_PROGRAM: code = CODE_SEC_PROGRAM;
      FCS_OP_SEC_LOCK:    code = CODE_SEC_LOCK;
      FCS_OP_SEC_ENTER:   code = CODE_SEC_ENTER;
      FCS_OP_ID_ENTER:    code = CODE_ID_ENTER;
      FCS_OP_QUERY_ENTER: code = CODE_QUERY;
      default:            code = erase ? CODE_ERASE_SETUP : CODE_EXIT;
    endcase
    case (step)
      3'd0:
        case (op)
          FCS_OP_SUSPEND:     begin wa = a; wd = {8'h00, CODE_SUSPEND}; last = 1'b1; end
          FCS_OP_RESUME:      begin wa = a; wd = {8'h00, CODE_RESUME};  last = 1'b1; end
          FCS_OP_EXIT_SHORT:  begin wa = a; wd = {8'h00, CODE_EXIT};    last = 1'b1; end
          FCS_OP_QUERY_SHORT:
          begin
            wa   = ADDR_QUERY_SHORT;
            wd   = {8'h00, CODE_QUERY};
            last = 1'b1;
          end
          default: ;
        endcase
      3'd1, 3'd4:
      begin
        wa = ADDR_UNLOCK2;
        wd = {8'h00, CODE_UNLOCK2};
      end
      3'd2:
      begin
        wd   = {8'h00, code};
        last = (op == FCS_OP_SEC_ENTER) || (op == FCS_OP_ID_ENTER) ||
               (op == FCS_OP_QUERY_ENTER) || (op == FCS_OP_EXIT);
      end
      3'd3:
        if (!erase)
        begin
          wa   = a;
          wd   = (op == FCS_OP_SEC_LOCK) ? LOCK_DATA : d;
          last = 1'b1;
        end
      default:
      begin
        // Final erase write; flash picks sector or block from high bits
        last = 1'b1;
        case (op)
          FCS_OP_SECTOR_ERASE: begin wa = a; wd = {8'h00, CODE_SECTOR}; end
          FCS_OP_BLOCK_ERASE:  begin wa = a; wd = {8'h00, CODE_BLOCK};  end
          default:             wd = {8'h00, CODE_CHIP};
        endcase
      end
    endcase
    return {last, wa, wd};
  endfunction

  // ------------------------------------------------------------------
  // Cycle request toward the pin engine
  // ------------------------------------------------------------------
  always_comb
  begin
    word       = seq_word(op_q, step_q, addr_q, data_q);
    needs_poll = (op_q == FCS_OP_PROGRAM) || (op_q == FCS_OP_SEC_PROGRAM) ||
                 (op_q == FCS_OP_SEC_LOCK) || (op_q == FCS_OP_SECTOR_ERASE) ||
                 (op_q == FCS_OP_BLOCK_ERASE) || (op_q == FCS_OP_CHIP_ERASE);
    cyc.req    = (st_q == S_ISSUE) || (st_q == S_POLL_ISSUE);
    cyc.write  = (st_q == S_ISSUE) && (op_q != FCS_OP_READ);
    cyc.addr   = cyc.write ? word[36:16] : addr_q;
    cyc.wdata  = word[15:0];                         // Upper byte held low except for step 3 user data
  end

  // ------------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q; op_d = op_q; addr_d = addr_q; data_d = data_q; step_d = step_q;
    cnt_d = cnt_q; prev_d = prev_q; polled_d = polled_q; err_d = err_q;
    rsp_d = rsp_q; rst_n_d = rst_n_q; valid_d = 1'b0;
    case (st_q)
      S_IDLE:
        if (cmd_valid_i)
        begin
          op_d   = cmd_op_i;
          addr_d = cmd_addr_i;
          data_d = cmd_data_i;
          step_d = 3'd0;
          err_d  = 1'b0;
          if (cmd_op_i == FCS_OP_RESET)
          begin
            rst_n_d = 1'b0;                          // Abort flash state
            cnt_d   = 8'(RP_CYC - 1);
            st_d    = S_RST_LOW;
          end
          else if (cmd_op_i == FCS_OP_SEC_PROGRAM &&
                   (cmd_addr_i < SEC_USER_FIRST || cmd_addr_i > SEC_USER_LAST))
          begin
            err_d = 1'b1;                            // Outside user segment
            st_d  = S_DONE;
          end
          else st_d = S_ISSUE;
        end
      S_ISSUE: st_d = S_WAIT;
      S_WAIT:
        if (cyc.done)
        begin
          if (op_q == FCS_OP_READ)
          begin
            rsp_d = cyc.rdata;
            st_d  = S_DONE;
          end
          else if (word[37])
          begin
            polled_d = 1'b0;
            st_d     = needs_poll ? S_POLL_ISSUE : S_DONE;
          end
          else
          begin
            step_d = step_q + 3'd1;
            st_d   = S_ISSUE;
          end
        end
      S_POLL_ISSUE: st_d = S_POLL_WAIT;
      S_POLL_WAIT:
        if (cyc.done)
        begin
          // Two equal toggle reads in a row mean the operation ended
          if (polled_q && cyc.rdata[TOGGLE_BIT] == prev_q)
          begin
            rsp_d = cyc.rdata;
            st_d  = S_DONE;
          end
          else
          begin
            prev_d   = cyc.rdata[TOGGLE_BIT];
            polled_d = 1'b1;
            st_d     = S_POLL_ISSUE;
          end
        end
      S_RST_LOW:
        if (cnt_q == 8'h00)
        begin
          rst_n_d = 1'b1;
          cnt_d   = 8'(RH_CYC - 1);
          st_d    = S_RST_HIGH;
        end
        else cnt_d = cnt_q - 8'h01;
      S_RST_HIGH:
        if (cnt_q == 8'h00) st_d = S_DONE;
        else cnt_d = cnt_q - 8'h01;
      S_DONE:
      begin
        valid_d = 1'b1;
        st_d    = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= S_IDLE; op_q <= FCS_OP_READ; addr_q <= 21'h000000; data_q <= 16'h0000;
      step_q <= 3'd0; cnt_q <= 8'h00; prev_q <= 1'b0; polled_q <= 1'b0;
      err_q <= 1'b0; rsp_q <= 16'h0000; rst_n_q <= 1'b1; valid_q <= 1'b0;
      prot_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d; op_q <= op_d; addr_q <= addr_d; data_q <= data_d;
      step_q <= step_d; cnt_q <= cnt_d; prev_q <= prev_d; polled_q <= polled_d;
      err_q <= err_d; rsp_q <= rsp_d; rst_n_q <= rst_n_d; valid_q <= valid_d;
      prot_n_q <= ~protect_boot_i;                   // Boot block guard pin
    end
  end

  // Answer and pin outputs
  assign cmd_ready_o      = (st_q == S_IDLE);
  assign rsp_valid_o      = valid_q;
  assign rsp_data_o       = rsp_q;
  assign rsp_error_o      = err_q;
  assign hard_reset_n_o   = rst_n_q;
  assign boot_protect_n_o = prot_n_q;

  // Pin engine
  fcs_bus_cycle u_cycle (
    .core_clk_i       (core_clk_i),
    .reset_n_i        (reset_n_i),
    .cyc              (cyc.eng),
    .flash_addr_o     (flash_addr_o),
    .data_pins_o      (data_pins_o),
    .data_pins_i      (data_pins_i),
    .data_pins_oe_n_o (data_pins_oe_n_o),
    .chip_select_n_o  (chip_select_n_o),
    .output_gate_n_o  (output_gate_n_o),
    .write_strobe_n_o (write_strobe_n_o)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_wr(int s);
    cyc.req && cyc.write && step_q == s;
  endsequence

  property p_prefix;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(1) |-> cyc.addr == ADDR_UNLOCK2 && cyc.wdata == {8'h00, CODE_UNLOCK2};
  endproperty
  a_prefix: assert property (p_prefix)
    else $error("second unlock write wrong");

  property p_program;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(2) ##0 (op_q == FCS_OP_PROGRAM) |-> cyc.wdata == {8'h00, CODE_PROGRAM};
  endproperty
  a_program: assert property (p_program)
    else $error("program code wrong");

  property p_sec_program;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(3) ##0 (op_q == FCS_OP_SEC_PROGRAM) |-> cyc.addr == addr_q && cyc.wdata == data_q;
  endproperty
  a_sec_program: assert property (p_sec_program)
    else $error("identifier word write wrong");

  property p_lock;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(3) ##0 (op_q == FCS_OP_SEC_LOCK) |-> cyc.wdata == LOCK_DATA;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock data not zero");

  property p_chip_erase;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(5) ##0 (op_q == FCS_OP_CHIP_ERASE) |->
        cyc.addr == ADDR_UNLOCK1 && cyc.wdata == {8'h00, CODE_CHIP};
  endproperty
  a_chip_erase: assert property (p_chip_erase)
    else $error("chip erase final write wrong");

  property p_suspend;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(0) ##0 (op_q == FCS_OP_SUSPEND) |-> cyc.wdata == {8'h00, CODE_SUSPEND}
        ##1 !cyc.req [*2];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend not a single write");

  property p_query_short;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_wr(0) ##0 (op_q == FCS_OP_QUERY_SHORT) |->
        cyc.addr == ADDR_QUERY_SHORT && cyc.wdata == {8'h00, CODE_QUERY};
  endproperty
  a_query_short: assert property (p_query_short)
    else $error("short query write wrong");

  property p_exit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      cyc.req && cyc.write && op_q == FCS_OP_EXIT_SHORT |-> cyc.wdata == {8'h00, CODE_EXIT};
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit code wrong");

  property p_upper_byte;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      cyc.req && cyc.write && step_q != 3'd3 |-> cyc.wdata[15:8] == 8'h00;
  endproperty
  a_upper_byte: assert property (p_upper_byte)
    else $error("upper byte not driven low");

  property p_poll_end;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_q == S_POLL_WAIT && cyc.done && polled_q && cyc.rdata[TOGGLE_BIT] == prev_q
        |-> ##2 rsp_valid_o;
  endproperty
  a_poll_end: assert property (p_poll_end)
    else $error("stable toggle did not finish");

endmodule

/* File: src/fcs_pkg.sv */
// Constants, opcodes and timing counts shared by the flash command host
package fcs_pkg;

  // ------------------------------------------------------------------
  // Bus widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------------
  // Command addresses and command codes
  // ------------------------------------------------------------------
  localparam logic [20:0] ADDR_UNLOCK1     = 21'h000555;
  localparam logic [20:0] ADDR_UNLOCK2     = 21'h0002AA;
  localparam logic [20:0] ADDR_QUERY_SHORT = 21'h000055;
  localparam logic [7:0]  CODE_UNLOCK1     = 8'hAA;
  localparam logic [7:0]  CODE_UNLOCK2     = 8'h55;
  localparam logic [7:0]  CODE_PROGRAM     = 8'hA0;
  localparam logic [7:0]  CODE_SEC_PROGRAM = 8'hA5;
  localparam logic [7:0]  CODE_SEC_LOCK    = 8'h85;
  localparam logic [7:0]  CODE_SEC_ENTER   = 8'h88;
  localparam logic [7:0]  CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CODE_SECTOR      = 8'h50;
  localparam logic [7:0]  CODE_BLOCK       = 8'h30;
  localparam logic [7:0]  CODE_CHIP        = 8'h10;
  localparam logic [7:0]  CODE_SUSPEND     = 8'hB0;
  localparam logic [7:0]  CODE_RESUME      = 8'h30;
  localparam logic [7:0]  CODE_ID_ENTER    = 8'h90;
  localparam logic [7:0]  CODE_QUERY       = 8'h98;
  localparam logic [7:0]  CODE_EXIT        = 8'hF0;
  localparam logic [15:0] LOCK_DATA        = 16'h0000;

  // ------------------------------------------------------------------
  // Status bits and security identifier map
  // ------------------------------------------------------------------
  localparam int          TOGGLE_BIT      = 6;
  localparam int          LOCK_FLAG_BIT   = 3;
  localparam logic [20:0] SEC_USER_FIRST  = 21'h000008;
  localparam logic [20:0] SEC_USER_LAST   = 21'h000087;
  localparam logic [20:0] SEC_LOCK_STATUS = 21'h0000FF;

  // ------------------------------------------------------------------
  // Timing, derived from a 10 ns clock
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int WRITE_PULSE_NS   = 40;
  localparam int READ_ACCESS_NS   = 80;
  localparam int RESET_PULSE_NS   = 500;
  localparam int RESET_RECOVER_NS = 50;
  localparam int WP_CYC  = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC  = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RH_CYC  = (RESET_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // User operations
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    FCS_OP_READ, FCS_OP_PROGRAM, FCS_OP_SEC_PROGRAM, FCS_OP_SEC_LOCK,
    FCS_OP_SECTOR_ERASE, FCS_OP_BLOCK_ERASE, FCS_OP_CHIP_ERASE,
    FCS_OP_SUSPEND, FCS_OP_RESUME, FCS_OP_SEC_ENTER, FCS_OP_ID_ENTER,
    FCS_OP_QUERY_ENTER, FCS_OP_QUERY_SHORT, FCS_OP_EXIT, FCS_OP_EXIT_SHORT,
    FCS_OP_RESET
  } fcs_op_t;

endpackage

/* File: src/fcs_cyc_if.sv */
// Single bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
interface fcs_cyc_if;
  logic        req;
  logic        write;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctrl (output req, write, addr, wdata, input done, rdata);
  modport eng  (input req, write, addr, wdata, output done, rdata);
endinterface

/* File: src/fcs_bus_cycle.sv */
// Pin engine: one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fcs_bus_cycle
  import fcs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Cycle request
  fcs_cyc_if.eng           cyc,
  // Flash pins
  output logic [20:0]      flash_addr_o,
  output logic [15:0]      data_pins_o,
  input  wire logic [15:0] data_pins_i,
  output logic             data_pins_oe_n_o,
  output logic             chip_select_n_o,
  output logic             output_gate_n_o,
  output logic             write_strobe_n_o
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} fcs_eng_t;

  fcs_eng_t    st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d, cs_n_q, cs_n_d, og_n_q, og_n_d, ws_n_q, ws_n_d;
  logic        oe_n_q, oe_n_d, done_q, done_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;

  // ------------------------------------------------------------------
  // Next state of the cycle
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; addr_d = addr_q; wdat_d = wdat_q;
    rdat_d = rdat_q; cs_n_d = cs_n_q; og_n_d = og_n_q; ws_n_d = ws_n_q;
    oe_n_d = oe_n_q; done_d = 1'b0;
    case (st_q)
      E_IDLE:
        if (cyc.req)
        begin
          wr_d   = cyc.write;
          addr_d = cyc.addr;
          wdat_d = cyc.wdata;
          cs_n_d = 1'b0;
          oe_n_d = ~cyc.write;          // Drive data only for writes
          st_d   = E_SETUP;
        end
      E_SETUP:
      begin
        if (wr_q)
        begin
          ws_n_d = 1'b0;                // Gate stays high while writing
          cnt_d  = 8'(WP_CYC - 1);
        end
        else
        begin
          og_n_d = 1'b0;
          cnt_d  = 8'(ACC_CYC - 1);
        end
        st_d = E_PULSE;
      end
      E_PULSE:
        if (cnt_q == 8'h00)
        begin
          ws_n_d = 1'b1;
          og_n_d = 1'b1;
          if (!wr_q) rdat_d = data_pins_i;
          st_d = E_HOLD;
        end
        else cnt_d = cnt_q - 8'h01;
      E_HOLD:
      begin
        cs_n_d = 1'b1;
        oe_n_d = 1'b1;
        done_d = 1'b1;
        st_d   = E_IDLE;
      end
      default: st_d = E_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // Cycle registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= E_IDLE; cnt_q <= 8'h00; wr_q <= 1'b0; addr_q <= 21'h000000;
      wdat_q <= 16'h0000; rdat_q <= 16'h0000; cs_n_q <= 1'b1; og_n_q <= 1'b1;
      ws_n_q <= 1'b1; oe_n_q <= 1'b1; done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; addr_q <= addr_d;
      wdat_q <= wdat_d; rdat_q <= rdat_d; cs_n_q <= cs_n_d; og_n_q <= og_n_d;
      ws_n_q <= ws_n_d; oe_n_q <= oe_n_d; done_q <= done_d;
    end
  end

  // Pins and answers straight from flops
  assign flash_addr_o     = addr_q;
  assign data_pins_o      = wdat_q;
  assign data_pins_oe_n_o = oe_n_q;
  assign chip_select_n_o  = cs_n_q;
  assign output_gate_n_o  = og_n_q;
  assign write_strobe_n_o = ws_n_q;
  assign cyc.done         = done_q;
  assign cyc.rdata        = rdat_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_gate_strobe_apart;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !(write_strobe_n_o == 1'b0 && output_gate_n_o == 1'b0);
  endproperty
  a_gate_strobe_apart: assert property (p_gate_strobe_apart)
    else $error("gate and strobe low together");

  property p_strobe_width;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(write_strobe_n_o) |-> (!write_strobe_n_o && !chip_select_n_o &&
        !data_pins_oe_n_o)[*4] ##1 write_strobe_n_o;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("write strobe width or data drive wrong");

endmodule

/* File: tb/fcs_flash_model.sv */
// Behavioural parallel flash that answers the host controller
`timescale 1ns/1ps
module fcs_flash_model
(
  // Flash pins
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] din_i,
  output logic      [15:0] dout_o,
  input  wire logic        cs_n_i,
  input  wire logic        og_n_i,
  input  wire logic        we_n_i
);
  int          n = 0;
  int          busy = 0;
  int          pre = 0;
  logic        tog = 1'b0;
  logic        locked = 1'b0;
  logic [15:0] w;
  logic [20:0] wa [256];
  logic [15:0] wd [256];
  logic [15:0] sid [136] = '{default: 16'hFFFF};
  // Latch each write on the strobe rise, start busy on program and erase
  always @(posedge we_n_i)
    if (!cs_n_i && og_n_i)
    begin
      wa[8'(n)] = addr_i;
      wd[8'(n)] = din_i;
      if (n > 0 && wd[8'(n - 1)][7:0] inside {8'hA0, 8'hA5, 8'h85})
        busy = 3;
      if (pre == 2 && din_i[7:0] inside {8'h50, 8'h30, 8'h10})
        busy = 3;
      // User words only, only while unlocked; erase never reaches them
      if (n > 0 && wd[8'(n - 1)][7:0] == 8'hA5 && !locked &&
          addr_i >= 21'h000008 && addr_i <= 21'h000087)
        sid[addr_i[7:0]] = din_i;
      if (n > 0 && wd[8'(n - 1)][7:0] == 8'h85 && din_i == 16'h0000)
        locked = 1'b1;
      // Unlock prefix on the low eleven address bits; a mismatch restarts it
      if (pre == 0 && addr_i[10:0] == 11'h555 && din_i[7:0] == 8'hAA)
        pre = 1;
      else if (pre == 1 && addr_i[10:0] == 11'h2AA && din_i[7:0] == 8'h55)
        pre = 2;
      else
        pre = 0;
      n++;
    end
  // Busy reads flip the toggle bit
  always @(negedge og_n_i)
    if (!cs_n_i && busy > 0)
    begin
      tog = ~tog;
      busy--;
    end
  // Status word shows lock flag; undriven pins show the inverse
  assign w      = {9'h000, tog, 2'h0, ~locked, 3'h0};
  assign dout_o = (!cs_n_i && !og_n_i) ? w : ~w;
endmodule

/* File: tb/fcs_host_tb_top.sv */
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module fcs_host_tb_top
  import fcs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cv = 1'b0;
  logic        pb = 1'b1;
  fcs_op_t     op = FCS_OP_READ;
  logic [20:0] ca = 21'h000000;
  logic [15:0] cd = 16'h0000;
  logic        rdy, rv, re, oe_n, cs_n, og_n, we_n, hr_n, bp_n;
  logic [15:0] rd, dq_o, dq_f, dq_i;
  logic [20:0] fa;
  int          err_count = 0;
  int          compares = 0;
  // Pin level from whichever side drives
  assign dq_i = oe_n ? dq_f : dq_o;
  fcs_host u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .cmd_valid_i(cv), .cmd_ready_o(rdy),
    .cmd_op_i(op), .cmd_addr_i(ca), .cmd_data_i(cd), .protect_boot_i(pb), .rsp_valid_o(rv),
    .rsp_data_o(rd), .rsp_error_o(re), .flash_addr_o(fa), .data_pins_o(dq_o),
    .data_pins_i(dq_i), .data_pins_oe_n_o(oe_n), .chip_select_n_o(cs_n),
    .output_gate_n_o(og_n), .write_strobe_n_o(we_n), .hard_reset_n_o(hr_n),
    .boot_protect_n_o(bp_n));
  fcs_flash_model u_flash (.addr_i(fa), .din_i(dq_i), .dout_o(dq_f), .cs_n_i(cs_n),
    .og_n_i(og_n), .we_n_i(we_n));
  // Clock
  initial
    forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command, then its write count, last write, error and reset span
  task automatic t_one(input fcs_op_t o, input logic [20:0] a, input logic [15:0] d,
    input int wn, input logic [20:0] la, input logic [15:0] ld, input logic ee);
    int n0, k, lo;
    n0 = u_flash.n;
    lo = 0;
    @(posedge clk);
    op <= o;
    ca <= a;
    cd <= d;
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    for (k = 0; k < 3000 && rv !== 1'b1; k++)
    begin
      @(negedge clk);
      lo += int'(hr_n === 1'b0);
    end
    chk("answer", 21'h1, 21'(rv));
    chk("ready", 21'h1, 21'(rdy));
    chk("error", 21'(ee), 21'(re));
    chk("writes", 21'(wn), 21'(u_flash.n - n0));
    if (wn > 0)
    begin
      chk("last_addr", la, u_flash.wa[8'(u_flash.n - 1)]);
      chk("last_data", 21'(ld), 21'(u_flash.wd[8'(u_flash.n - 1)]));
    end
    if (wn > 2)
      chk("first_data", 21'h0000AA, 21'(u_flash.wd[8'(n0)]));
    if (o == FCS_OP_RESET)
      chk("reset_span", 21'(RP_CYC), 21'(lo));
    $display("Test %s done", o.name());
  endtask
  task automatic t_writes();
    t_one(FCS_OP_PROGRAM, 21'h000123, 16'h1234, 4, 21'h000123, 16'h1234, 0);
    t_one(FCS_OP_SEC_PROGRAM, 21'h000087, 16'h00FF, 4, 21'h000087, 16'h00FF, 0);
    t_one(FCS_OP_SEC_LOCK, 21'h000040, 16'h1111, 4, 21'h000040, 16'h0000, 0);
    t_one(FCS_OP_SECTOR_ERASE, 21'h000800, 0, 6, 21'h000800, 16'h0050, 0);
    t_one(FCS_OP_BLOCK_ERASE, 21'h008000, 0, 6, 21'h008000, 16'h0030, 0);
    t_one(FCS_OP_CHIP_ERASE, 21'h000000, 0, 6, 21'h000555, 16'h0010, 0);
    t_one(FCS_OP_SUSPEND, 21'h1FFFFF, 0, 1, 21'h1FFFFF, 16'h00B0, 0);
    t_one(FCS_OP_RESUME, 21'h000000, 0, 1, 21'h000000, 16'h0030, 0);
    chk("sid_word", 21'h0000FF, 21'(u_flash.sid[8'h87]));
  endtask
  task automatic t_modes();
    t_one(FCS_OP_SEC_ENTER, 21'h000000, 0, 3, 21'h000555, 16'h0088, 0);
    t_one(FCS_OP_READ, 21'h0000FF, 0, 0, 21'h0, 16'h0, 0);
    chk("lock_flag", 21'h0, 21'(rd[LOCK_FLAG_BIT]));
    t_one(FCS_OP_EXIT_SHORT, 21'h000777, 0, 1, 21'h000777, 16'h00F0, 0);
    t_one(FCS_OP_ID_ENTER, 21'h000000, 0, 3, 21'h000555, 16'h0090, 0);
    t_one(FCS_OP_EXIT, 21'h000000, 0, 3, 21'h000555, 16'h00F0, 0);
    t_one(FCS_OP_QUERY_ENTER, 21'h000000, 0, 3, 21'h000555, 16'h0098, 0);
    t_one(FCS_OP_QUERY_SHORT, 21'h000000, 0, 1, 21'h000055, 16'h0098, 0);
  endtask
  task automatic t_faults();
    t_one(FCS_OP_SEC_PROGRAM, 21'h000088, 16'h0001, 0, 21'h0, 16'h0, 1);
    t_one(FCS_OP_SEC_PROGRAM, 21'h000007, 16'h0001, 0, 21'h0, 16'h0, 1);
    t_one(FCS_OP_RESET, 21'h000000, 0, 0, 21'h0, 16'h0, 0);
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d errors", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk("boot_protect", 21'h0, 21'(bp_n));
    @(posedge clk);
    pb <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("boot_release", 21'h1, 21'(bp_n));
    t_writes();
    t_modes();
    t_faults();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #500us;
    err_count++;
    finish_test();
  end
endmodule
